// ---- sld_pkg.sv ----
// Shared constants and types of the status lamp driver
package sld_pkg;

    // ************************************************************
    // Clock and blink timing
    // ************************************************************
    localparam int unsigned CLK_HZ          = 125_000_000;
    localparam int unsigned FAST_HALF_MS    = 250;
    localparam int unsigned FAST_HALF_CYC   = (CLK_HZ / 1000) * FAST_HALF_MS;
    localparam int unsigned SLOW_PER_FAST   = 4;
    localparam int unsigned SLOW_CNT_W      = 2;

    // ************************************************************
    // Register map, byte addresses
    // ************************************************************
    localparam int unsigned ADDR_W          = 8;
    localparam logic [7:0]  OFF_CTRL        = 8'h00;
    localparam logic [7:0]  OFF_DIVIDER     = 8'h04;
    localparam logic [7:0]  OFF_STATUS      = 8'h08;
    localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h0c;
    localparam logic [7:0]  OFF_IRQ_CLEAR   = 8'h10;
    localparam logic [7:0]  OFF_IRQ_ENABLE  = 8'h14;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned CTRL_IDENT_BIT  = 0;
    localparam int unsigned CTRL_ACK_BIT    = 1;
    localparam int unsigned ST_READY_LSB    = 0;
    localparam int unsigned ST_ENC_BIT      = 2;
    localparam int unsigned ST_FAULT_BIT    = 3;
    localparam int unsigned ST_DONE_BIT     = 4;
    localparam int unsigned ST_SUPPLY_BIT   = 5;
    localparam int unsigned ST_IDENT_BIT    = 6;
    localparam int unsigned IRQ_W           = 3;
    localparam int unsigned IRQ_FAULT_BIT   = 0;
    localparam int unsigned IRQ_DONE_BIT    = 1;
    localparam int unsigned IRQ_SUPPLY_BIT  = 2;
    localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;

    // ************************************************************
    // Lamp colours: two LEDs, orange is both lit
    // ************************************************************
    typedef enum logic [1:0] {
        LAMP_OFF,
        LAMP_GREEN,
        LAMP_ORANGE,
        LAMP_RED
    } sld_colour_e;

endpackage

// ---- sld_blink_if.sv ----
// Carrier between the lamp logic and the blink divider
interface sld_blink_if;
    logic [31:0] half_period;
    logic        tick;
    logic        phase_fast;
    logic        phase_slow;

    modport div (
        input  half_period,
        output tick,
        output phase_fast,
        output phase_slow
    );

    modport user (
        output half_period,
        input  tick,
        input  phase_fast,
        input  phase_slow
    );
endinterface

// ---- sld_blink_div.sv ----
// Programmable divider making the fast and slow blink phases
module sld_blink_div (
    // Clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // Divider link
    sld_blink_if.div   blk
);

    logic [31:0]                    cnt;
    logic [sld_pkg::SLOW_CNT_W-1:0] slow_cnt;
    logic [31:0]                    limit;

    // A zero setting would stall the counter, treat it as one
    assign limit = (blk.half_period == sld_pkg::ZERO_WORD) ? 32'h0000_0001 : blk.half_period;

    // ************************************************************
    // Fast half period counter
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt      <= 32'h0000_0000;
            blk.tick <= 1'b0;
        end else if (cnt >= limit - 32'h0000_0001) begin
            cnt      <= 32'h0000_0000;
            blk.tick <= 1'b1;
        end else begin
            cnt      <= cnt + 32'h0000_0001;
            blk.tick <= 1'b0;
        end
    end

    // ************************************************************
    // Phases: slow half period is four fast ones
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blk.phase_fast <= 1'b0;
            blk.phase_slow <= 1'b0;
            slow_cnt       <= 2'h0;
        end else if (blk.tick) begin
            blk.phase_fast <= ~blk.phase_fast;
            slow_cnt       <= slow_cnt + 2'h1;
            if (slow_cnt == sld_pkg::SLOW_CNT_W'(sld_pkg::SLOW_PER_FAST - 1)) begin
                blk.phase_slow <= ~blk.phase_slow;
            end
        end
    end

endmodule

// ---- sld_status_led.sv ----
// Status lamp driver: ready lamp, encoder supply lamp, APB registers
//
// Chosen here: the APB interface to the registers and the address map.
module sld_status_led #(
    parameter logic [31:0] FAST_HALF_CYC = 32'(sld_pkg::FAST_HALF_CYC)
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Status from pins
    input  wire logic        supply_ok_pin,
    input  wire logic        enc_above_5v_pin,
    // Status from module logic
    input  wire logic        link_cyclic,
    input  wire logic        link_establishing,
    input  wire logic        fault_present,
    input  wire logic        fw_downloading,
    input  wire logic        fw_download_done,
    // Lamps
    output logic             ready_green,
    output logic             ready_red,
    output logic             enc_lamp_orange,
    // Interrupt
    output logic             irq
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [2:0]                   supply_sync;
    logic [2:0]                   enc_sync;
    logic                         supply_ok;
    logic                         enc_above_5v;
    logic                         fault_latched;
    logic                         done_latched;
    logic                         identify_blink_request;
    logic                         ident_req_q;
    logic                         ident_red_pair;
    logic                         fault_ack;
    logic [31:0]                  divider;
    logic [sld_pkg::IRQ_W-1:0]    irq_status;
    logic [sld_pkg::IRQ_W-1:0]    irq_enable;
    logic [sld_pkg::IRQ_W-1:0]    irq_event;
    logic                         supply_ok_q;
    logic                         done_q;
    sld_pkg::sld_colour_e         base_colour;
    sld_pkg::sld_colour_e         next_colour;
    logic                         wr_en;
    logic                         rd_setup;
    logic [31:0]                  rd_word;
    logic                         addr_ok;

    sld_blink_if blk ();

    // ************************************************************
    // Address decode, used for read, write and error
    // ************************************************************
    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
        is_reg = (a == off);
    endfunction

    assign addr_ok = is_reg(paddr, sld_pkg::OFF_CTRL) | is_reg(paddr, sld_pkg::OFF_DIVIDER)
                   | is_reg(paddr, sld_pkg::OFF_STATUS) | is_reg(paddr, sld_pkg::OFF_IRQ_STATUS)
                   | is_reg(paddr, sld_pkg::OFF_IRQ_CLEAR)
                   | is_reg(paddr, sld_pkg::OFF_IRQ_ENABLE);

    // ************************************************************
    // Pin synchronisers: level accepted when stages two and three agree
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_sync <= 3'h0;
            enc_sync    <= 3'h0;
        end else begin
            supply_sync <= {supply_sync[1:0], supply_ok_pin};
            enc_sync    <= {enc_sync[1:0], enc_above_5v_pin};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_ok    <= 1'b0;
            enc_above_5v <= 1'b0;
        end else begin
            if (supply_sync[1] == supply_sync[2]) begin
                supply_ok <= supply_sync[2];
            end
            if (enc_sync[1] == enc_sync[2]) begin
                enc_above_5v <= enc_sync[2];
            end
        end
    end

    // ************************************************************
    // Fault and download latches
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_latched <= 1'b0;
        end else if (fault_present) begin
            fault_latched <= 1'b1;
        end else if (fault_ack) begin
            fault_latched <= 1'b0;
        end
    end

    // Only a reset, i.e. a power cycle, ends the post download state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_latched <= 1'b0;
        end else if (fw_download_done) begin
            done_latched <= 1'b1;
        end
    end

    // ************************************************************
    // Ready lamp colour without identification
    // ************************************************************
    always_comb begin
        if (!supply_ok) begin
            base_colour = sld_pkg::LAMP_OFF;
        end else if (fw_downloading) begin
            base_colour = blk.phase_slow ? sld_pkg::LAMP_RED : sld_pkg::LAMP_GREEN;
        end else if (done_latched) begin
            base_colour = blk.phase_fast ? sld_pkg::LAMP_RED : sld_pkg::LAMP_GREEN;
        end else if (fault_latched) begin
            base_colour = sld_pkg::LAMP_RED;
        end else if (link_cyclic) begin
            base_colour = sld_pkg::LAMP_GREEN;
        end else if (link_establishing) begin
            base_colour = sld_pkg::LAMP_ORANGE;
        end else begin
            base_colour = sld_pkg::LAMP_OFF;
        end
    end

    // ************************************************************
    // Identification: pair chosen at the rising edge of the request
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ident_req_q    <= 1'b0;
            ident_red_pair <= 1'b0;
        end else begin
            ident_req_q <= identify_blink_request;
            if (identify_blink_request && !ident_req_q) begin
                ident_red_pair <= (base_colour == sld_pkg::LAMP_RED);
            end
        end
    end

    // Final colour: no supply first, then identification
    always_comb begin
        if (!supply_ok) begin
            next_colour = sld_pkg::LAMP_OFF;
        end else if (identify_blink_request && ident_req_q) begin
            if (blk.phase_fast) begin
                next_colour = sld_pkg::LAMP_ORANGE;
            end else if (ident_red_pair) begin
                next_colour = sld_pkg::LAMP_RED;
            end else begin
                next_colour = sld_pkg::LAMP_GREEN;
            end
        end else begin
            next_colour = base_colour;
        end
    end

    // ************************************************************
    // Lamp outputs
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_green <= 1'b0;
            ready_red   <= 1'b0;
        end else begin
            case (next_colour)
                sld_pkg::LAMP_GREEN: begin
                    ready_green <= 1'b1;
                    ready_red   <= 1'b0;
                end
                sld_pkg::LAMP_ORANGE: begin
                    ready_green <= 1'b1;
                    ready_red   <= 1'b1;
                end
                sld_pkg::LAMP_RED: begin
                    ready_green <= 1'b0;
                    ready_red   <= 1'b1;
                end
                default: begin
                    ready_green <= 1'b0;
                    ready_red   <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enc_lamp_orange <= 1'b0;
        end else begin
            enc_lamp_orange <= supply_ok && enc_above_5v;
        end
    end

    // ************************************************************
    // Blink divider
    // ************************************************************
    assign blk.half_period = divider;

    sld_blink_div u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .blk     (blk.div)
    );

    // ************************************************************
    // APB handshake and write side
    // ************************************************************
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !addr_ok;
    assign wr_en    = psel && penable && pwrite && addr_ok;
    assign rd_setup = psel && !penable && !pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            identify_blink_request <= 1'b0;
            fault_ack              <= 1'b0;
        end else begin
            fault_ack <= 1'b0;
            if (wr_en && is_reg(paddr, sld_pkg::OFF_CTRL)) begin
                identify_blink_request <= pwdata[sld_pkg::CTRL_IDENT_BIT];
                fault_ack              <= pwdata[sld_pkg::CTRL_ACK_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divider <= FAST_HALF_CYC;
        end else if (wr_en && is_reg(paddr, sld_pkg::OFF_DIVIDER)) begin
            divider <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable <= 3'h0;
        end else if (wr_en && is_reg(paddr, sld_pkg::OFF_IRQ_ENABLE)) begin
            irq_enable <= pwdata[sld_pkg::IRQ_W-1:0];
        end
    end

    // ************************************************************
    // Interrupt events: set wins over a clear in the same cycle
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_ok_q <= 1'b0;
            done_q      <= 1'b0;
        end else begin
            supply_ok_q <= supply_ok;
            done_q      <= done_latched;
        end
    end

    always_comb begin
        irq_event                         = 3'h0;
        irq_event[sld_pkg::IRQ_FAULT_BIT]  = fault_present && !fault_latched;
        irq_event[sld_pkg::IRQ_DONE_BIT]   = done_latched && !done_q;
        irq_event[sld_pkg::IRQ_SUPPLY_BIT] = supply_ok_q && !supply_ok;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 3'h0;
        end else if (wr_en && is_reg(paddr, sld_pkg::OFF_IRQ_CLEAR)) begin
            irq_status <= (irq_status & ~pwdata[sld_pkg::IRQ_W-1:0]) | irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_enable);
        end
    end

    // ************************************************************
    // Read data, captured in the setup cycle
    // ************************************************************
    always_comb begin
        rd_word = sld_pkg::ZERO_WORD;
        if (is_reg(paddr, sld_pkg::OFF_CTRL)) begin
            rd_word[sld_pkg::CTRL_IDENT_BIT] = identify_blink_request;
        end else if (is_reg(paddr, sld_pkg::OFF_DIVIDER)) begin
            rd_word = divider;
        end else if (is_reg(paddr, sld_pkg::OFF_STATUS)) begin
            rd_word[sld_pkg::ST_READY_LSB +: 2] = next_colour;
            rd_word[sld_pkg::ST_ENC_BIT]        = enc_lamp_orange;
            rd_word[sld_pkg::ST_FAULT_BIT]      = fault_latched;
            rd_word[sld_pkg::ST_DONE_BIT]       = done_latched;
            rd_word[sld_pkg::ST_SUPPLY_BIT]     = supply_ok;
            rd_word[sld_pkg::ST_IDENT_BIT]      = identify_blink_request;
        end else if (is_reg(paddr, sld_pkg::OFF_IRQ_STATUS)) begin
            rd_word[sld_pkg::IRQ_W-1:0] = irq_status;
        end else if (is_reg(paddr, sld_pkg::OFF_IRQ_ENABLE)) begin
            rd_word[sld_pkg::IRQ_W-1:0] = irq_enable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= rd_word;
        end
    end

endmodule

// ---- sld_status_led_chk.sv ----
// Concurrent checks on the ports of the status lamp driver
module sld_status_led_chk #(
    parameter logic [31:0] FAST_HALF_CYC = 32'h0000_0008
) (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Status inputs
    input wire logic        supply_ok_pin,
    input wire logic        enc_above_5v_pin,
    input wire logic        link_cyclic,
    input wire logic        link_establishing,
    input wire logic        fault_present,
    input wire logic        fw_downloading,
    input wire logic        fw_download_done,
    // Lamps and interrupt
    input wire logic        ready_green,
    input wire logic        ready_red,
    input wire logic        enc_lamp_orange,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ID_WIN = 3 * int'(FAST_HALF_CYC);
    logic [3:0] sup_cnt;
    logic       ident_q;
    logic       flt_q;
    logic       done_q;
    wire        ctrl_wr = psel && penable && pwrite && paddr == sld_pkg::OFF_CTRL;
    wire        sup     = sup_cnt == 4'h8;
    wire        quiet   = sup && !ident_q && !done_q && !fw_downloading;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Supply counts as settled once the pin has been high for eight edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sup_cnt <= 4'h0;
        end else if (!supply_ok_pin) begin
            sup_cnt <= 4'h0;
        end else if (!sup) begin
            sup_cnt <= sup_cnt + 4'h1;
        end
    end

    // Shadow of identify request, fault latch and download-done latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ident_q <= 1'b0;
            flt_q   <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            if (ctrl_wr) ident_q <= pwdata[sld_pkg::CTRL_IDENT_BIT];
            if (fault_present) flt_q <= 1'b1;
            else if (ctrl_wr && pwdata[sld_pkg::CTRL_ACK_BIT]) flt_q <= 1'b0;
            if (fw_download_done) done_q <= 1'b1;
        end
    end

    sequence s_fault_held; (quiet && flt_q) [*2]; endsequence
    sequence s_ident_on; (sup && ident_q) [*2]; endsequence

    property p_sup_dark; !supply_ok_pin [*8] |-> !(ready_green || ready_red || enc_lamp_orange);
    endproperty
    a_sup_dark: assert property (p_sup_dark) else $error("lamp lit without supply");
    property p_enc_off; !enc_above_5v_pin [*8] |-> !enc_lamp_orange; endproperty
    a_enc_off: assert property (p_enc_off) else $error("encoder lamp lit at low supply");
    property p_enc_on; (supply_ok_pin && enc_above_5v_pin) [*8] |-> enc_lamp_orange; endproperty
    a_enc_on: assert property (p_enc_on) else $error("encoder lamp dark");
    property p_fault_red; s_fault_held |-> ready_red && !ready_green; endproperty
    a_fault_red: assert property (p_fault_red) else $error("fault not shown red");
    property p_green;
        (quiet && !flt_q && !fault_present && link_cyclic) [*3] |-> ready_green && !ready_red;
    endproperty
    a_green: assert property (p_green) else $error("cyclic link not green");
    property p_orange;
        (quiet && !flt_q && !fault_present && !link_cyclic && link_establishing) [*3]
            |-> ready_green && ready_red;
    endproperty
    a_orange: assert property (p_orange) else $error("link setup not orange");
    property p_blink;
        (sup && !ident_q && (fw_downloading || done_q)) [*3] |-> ready_green != ready_red;
    endproperty
    a_blink: assert property (p_blink) else $error("download blink not green or red");
    property p_ident; s_ident_on |-> ##[0:ID_WIN] (ready_green && ready_red || !ident_q);
    endproperty
    a_ident: assert property (p_ident) else $error("identify blink shows no orange");
    property p_unmapped;
        psel && penable && paddr > sld_pkg::OFF_IRQ_ENABLE |-> pslverr && (pwrite || prdata == 32'h0);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
endmodule

// ---- sld_lamp_model.sv ----
// Behavioural model of the two-die ready lamp on the front panel
module sld_lamp_model (
    // Clock
    input  wire logic            pclk,
    // Lamp dies
    input  wire logic            green,
    input  wire logic            red,
    // Seen colour and length of the last steady stretch in cycles
    output sld_pkg::sld_colour_e colour,
    output int unsigned          hold_len
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned          run;
    sld_pkg::sld_colour_e last = sld_pkg::LAMP_OFF;
    // Both dies lit looks orange
    assign colour = sld_pkg::sld_colour_e'({red, green ^ red});
    always @(posedge pclk) begin
        last <= colour;
        if (colour != last) begin
            hold_len <= run;
            run      <= 1;
        end else begin
            run <= run + 1;
        end
    end
endmodule

// ---- testbench.sv ----
// Self-checking bench of the status lamp driver
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] DIV = 32'h0000_0008;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, rnd;
    logic        supply_ok_pin, enc_above_5v_pin, link_cyclic, link_establishing;
    logic        fault_present, fw_downloading, fw_download_done;
    logic        ready_green, ready_red, enc_lamp_orange, irq;
    logic [3:0]  seen;
    int          bad_count, samples_checked, seed;
    int unsigned hold_len;
    sld_pkg::sld_colour_e colour;

    always #4 pclk = ~pclk;

    sld_status_led #(.FAST_HALF_CYC(DIV)) i_sld_status_led (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .supply_ok_pin(supply_ok_pin), .enc_above_5v_pin(enc_above_5v_pin),
        .link_cyclic(link_cyclic), .link_establishing(link_establishing),
        .fault_present(fault_present), .fw_downloading(fw_downloading),
        .fw_download_done(fw_download_done), .ready_green(ready_green),
        .ready_red(ready_red), .enc_lamp_orange(enc_lamp_orange), .irq(irq));
    sld_lamp_model i_sld_lamp_model (.pclk(pclk), .green(ready_green), .red(ready_red),
        .colour(colour), .hold_len(hold_len));

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic watch(input int n);
        seen = 4'h0;
        repeat (n) begin
            @(posedge pclk);
            seen[colour] = 1'b1;
        end
    endtask

    function automatic sld_pkg::sld_colour_e link_col(input logic c, input logic e);
        if (c) return sld_pkg::LAMP_GREEN;
        if (e) return sld_pkg::LAMP_ORANGE;
        return sld_pkg::LAMP_OFF;
    endfunction

    initial begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; supply_ok_pin = 1'b1; enc_above_5v_pin = 1'b1;
        link_cyclic = 1'b0; link_establishing = 1'b0; fault_present = 1'b0;
        fw_downloading = 1'b0; fw_download_done = 1'b0;
        bad_count = 0; samples_checked = 0; seed = 32'h9fbe;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, sld_pkg::OFF_DIVIDER, 32'h0);
        chk("divider reset", rd, DIV);
        apb(1'b0, sld_pkg::OFF_CTRL, 32'h0);
        chk("ctrl reset", rd, 32'h0);
        apb(1'b1, 8'h40, 32'hffff_ffff);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped read", {rd[30:0], err}, 32'h1);
        $display("test registers done");
        repeat (12) begin
            rnd = $random(seed);
            link_cyclic <= rnd[0];
            link_establishing <= rnd[1];
            repeat (12) @(posedge pclk);
            chk("link colour", colour, link_col(rnd[0], rnd[1]));
            chk("encoder lamp", enc_lamp_orange, 32'h1);
        end
        $display("test link done");
        link_cyclic <= 1'b1;
        apb(1'b1, sld_pkg::OFF_IRQ_ENABLE, 32'h1);
        fault_present <= 1'b1;
        @(posedge pclk);
        fault_present <= 1'b0;
        repeat (20) @(posedge pclk);
        chk("fault colour", colour, sld_pkg::LAMP_RED);
        chk("fault irq", irq, 32'h1);
        apb(1'b1, sld_pkg::OFF_IRQ_CLEAR, 32'h1);
        @(posedge pclk);
        chk("irq cleared", irq, 32'h0);
        apb(1'b1, sld_pkg::OFF_CTRL, 32'h1);
        watch(40);
        chk("identify pair red", seen, 4'b1100);
        apb(1'b1, sld_pkg::OFF_CTRL, 32'h2);
        repeat (3) @(posedge pclk);
        chk("fault cleared", colour, sld_pkg::LAMP_GREEN);
        apb(1'b1, sld_pkg::OFF_CTRL, 32'h1);
        watch(40);
        chk("identify pair green", seen, 4'b0110);
        apb(1'b1, sld_pkg::OFF_CTRL, 32'h0);
        $display("test fault and identify done");
        enc_above_5v_pin <= 1'b0;
        repeat (8) @(posedge pclk);
        chk("encoder lamp low", enc_lamp_orange, 32'h0);
        apb(1'b1, sld_pkg::OFF_IRQ_ENABLE, 32'h4);
        supply_ok_pin <= 1'b0;
        repeat (8) @(posedge pclk);
        chk("no supply colour", colour, sld_pkg::LAMP_OFF);
        chk("supply irq", irq, 32'h1);
        supply_ok_pin <= 1'b1;
        enc_above_5v_pin <= 1'b1;
        apb(1'b1, sld_pkg::OFF_IRQ_CLEAR, 32'h4);
        repeat (10) @(posedge pclk);
        chk("supply back", {irq, enc_lamp_orange, colour}, 32'h5);
        $display("test supply done");
        fw_downloading <= 1'b1;
        watch(100);
        chk("download colours", seen, 4'b1010);
        chk("download half period", hold_len, 4 * DIV);
        fw_downloading <= 1'b0;
        fw_download_done <= 1'b1;
        @(posedge pclk);
        fw_download_done <= 1'b0;
        watch(40);
        chk("done colours", seen, 4'b1010);
        chk("done half period", hold_len, DIV);
        apb(1'b1, sld_pkg::OFF_DIVIDER, 32'h4);
        watch(30);
        chk("divided half period", hold_len, 32'h4);
        $display("test download done");
        report_and_stop();
    end
endmodule

bind sld_status_led sld_status_led_chk #(.FAST_HALF_CYC(FAST_HALF_CYC)) i_sld_status_led_chk (.*);
